//--- rtl/imc_pkg.sv
package imc_pkg;

    // ------------------------------------------------------------------
    // Clocking and time base
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TS_TICK_PS    = 8000;
    localparam int TS_TICK_RAW   = TS_TICK_PS / CLK_PERIOD_PS;
    localparam int TS_TICK_CYC   = (TS_TICK_RAW < 1) ? 1 : TS_TICK_RAW;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int TS_W   = 64;
    localparam int CNT_W  = 32;
    localparam int SNAP_W = 32;
    localparam int LINE_N = 4;
    localparam int PRE_W  = 8;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_APPEND    = 8'h00;
    localparam logic [7:0] OFF_KIND_SEL  = 8'h04;
    localparam logic [7:0] OFF_KIND_ON   = 8'h08;
    localparam logic [7:0] OFF_CNT_CFG   = 8'h0c;
    localparam logic [7:0] OFF_CLEAR_CMD = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;
    localparam logic [7:0] OFF_TS_LO     = 8'h18;
    localparam logic [7:0] OFF_TS_HI     = 8'h1c;
    localparam logic [7:0] OFF_TRIG_CNT  = 8'h20;
    localparam logic [7:0] OFF_LINES     = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int APPEND_BIT    = 0;
    localparam int KIND_SEL_LSB  = 0;
    localparam int KIND_ON_BIT   = 0;
    localparam int PICK_BIT      = 0;
    localparam int ORIGIN_LSB    = 4;
    localparam int CLEAR_SRC_LSB = 8;
    localparam int CMD_BIT       = 0;
    localparam int STAT_FREE_BIT = 0;
    localparam int STAT_ON_LSB   = 1;

    // ------------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IMC_KIND_TS,
        IMC_KIND_CNT,
        IMC_KIND_LINES,
        IMC_KIND_RSVD
    } imc_kind_t;

    typedef enum logic [1:0] {
        IMC_CLR_OFF,
        IMC_CLR_LINE_ONE,
        IMC_CLR_LINE_TWO,
        IMC_CLR_SOFTWARE
    } imc_clear_t;

    localparam logic       PICK_TRIGGER_UNIT   = 1'b0;
    localparam logic [1:0] ORIGIN_FRAME_TRIG   = 2'h0;
    localparam logic       RST_APPEND          = 1'b0;
    localparam imc_kind_t  RST_KIND_SEL        = IMC_KIND_TS;
    localparam logic [2:0] RST_KIND_ON         = 3'h0;
    localparam logic       RST_PICK            = PICK_TRIGGER_UNIT;
    localparam logic [1:0] RST_ORIGIN          = ORIGIN_FRAME_TRIG;
    localparam imc_clear_t RST_CLEAR_SRC       = IMC_CLR_OFF;
    localparam logic [CNT_W-1:0] RST_TRIG_CNT  = 32'h0000_0000;
    localparam logic [TS_W-1:0]  RST_TS        = 64'h0000_0000_0000_0000;

endpackage : imc_pkg

//--- rtl/imc_line_sync.sv
`timescale 1ns/1ps

module imc_line_sync (
    input  wire logic                       i_clk_sys,  // System clock
    input  wire logic                       i_rstn,     // Async reset, active low
    input  wire logic [imc_pkg::LINE_N-1:0] i_pin,      // Raw line levels
    output logic      [imc_pkg::LINE_N-1:0] o_level,    // Synchronised levels
    output logic      [imc_pkg::LINE_N-1:0] o_rise      // One-cycle rising edge
);

    logic [imc_pkg::LINE_N-1:0] meta_ff;
    logic [imc_pkg::LINE_N-1:0] sync_ff;
    logic [imc_pkg::LINE_N-1:0] prev_ff;

    // ------------------------------------------------------------------
    // Two-stage synchroniser and edge detect per line
    // ------------------------------------------------------------------
    for (genvar g = 0; g < imc_pkg::LINE_N; g++) begin : g_line
        always_ff @(posedge i_clk_sys or negedge i_rstn) begin
            if (!i_rstn) begin
                meta_ff[g] <= 1'b0;
                sync_ff[g] <= 1'b0;
                prev_ff[g] <= 1'b0;
            end else begin
                meta_ff[g] <= i_pin[g];
                sync_ff[g] <= meta_ff[g];
                prev_ff[g] <= sync_ff[g];
            end
        end
        assign o_rise[g] = sync_ff[g] & ~prev_ff[g]; // [R20]
    end

    assign o_level = sync_ff;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    rise_single_a: assert property (o_rise[0] |=> !o_rise[0]) // [R20]
        else $error("line rise pulse lasted more than one cycle");

endmodule : imc_line_sync

//--- rtl/imc_trig_counter.sv
`timescale 1ns/1ps

module imc_trig_counter (
    input  wire logic                      i_clk_sys, // System clock
    input  wire logic                      i_rstn,    // Async reset, active low
    input  wire logic                      i_count,   // Count one trigger
    input  wire logic                      i_clear,   // Clear request
    output logic      [imc_pkg::CNT_W-1:0] o_count    // Current count
);

    logic [imc_pkg::CNT_W-1:0] cnt_ff;
    logic [imc_pkg::CNT_W-1:0] nxt_cnt;

    // Clear then count: a trigger that meets a clear is the first of a new run
    always_comb begin
        nxt_cnt = cnt_ff;
        if (i_clear) begin
            nxt_cnt = imc_pkg::RST_TRIG_CNT; // [R14]
        end
        if (i_count) begin
            nxt_cnt = nxt_cnt + 32'h0000_0001; // [R7] [R8]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_ff <= imc_pkg::RST_TRIG_CNT; // [R10]
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_count = cnt_ff;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    cnt_step_a: assert property (i_count && !i_clear |=> cnt_ff == $past(cnt_ff) + 32'h1) // [R7]
        else $error("trigger count did not advance by one");
    cnt_wrap_a: assert property (i_count && !i_clear && cnt_ff == 32'hffff_ffff
                                 |=> cnt_ff == 32'h0) // [R8]
        else $error("trigger count did not wrap to zero");
    cnt_clear_a: assert property (i_clear |=> cnt_ff == {31'h0, $past(i_count)}) // [R11]
        else $error("clear did not restart the trigger count");

endmodule : imc_trig_counter

//--- rtl/imc_top.sv
// Overview of operation
// R1: 64-bit time stamp counts 8 ns ticks
// R2: Time stamp restarts at reset
// R3: Latch time stamp at trigger, append if on
// R4: Per-kind enable only while append mode active
// R5: Append mode off turns every kind off
// R6: Software selects kind, then sets its enable
// R7: Trigger count starts at 1, +1 per trigger
// R8: Trigger count wraps to zero after maximum
// R9: Free-run mode gives no trigger count
// R10: Trigger count cleared to zero at power-off; here it is cleared when i_rstn is low
// R11: Clear source: line one, two, software, off
// R12: Clear source defaults to off after reset
// R13: Software picks unit and event before clear source
// R14: Software clear command clears trigger count
// R15: Trigger count chunk appended when enabled
// R16: Sample all line levels at each trigger
// R17: Snapshot bit is line level at trigger
// R18: Line snapshot chunk appended when enabled
// R19: Fixed line-to-bit map, unused bits zero
// R20: Line clears act once per synchronised edge
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module imc_top (
    input  wire logic        i_clk_sys,      // System clock, 125 MHz
    input  wire logic        i_rstn,         // Async reset, active low
    // AHB-Lite slave
    input  wire logic        i_hsel,         // Slave select
    input  wire logic [31:0] i_haddr,        // Address
    input  wire logic [1:0]  i_htrans,       // Transfer type
    input  wire logic        i_hwrite,       // Write, not read
    input  wire logic [2:0]  i_hsize,        // Transfer size
    input  wire logic [31:0] i_hwdata,       // Write data
    input  wire logic        i_hready,       // Bus ready
    output logic             o_hreadyout,    // Slave ready
    output logic             o_hresp,        // Response, always OKAY
    output logic      [31:0] o_hrdata,       // Read data
    // Acquisition side
    input  wire logic        i_acq_trigger,  // Acquisition trigger pulse
    input  wire logic        i_free_run,     // Continuous free-running mode
    input  wire logic [1:0]  i_input_line,   // Input line one and two pins
    input  wire logic [1:0]  i_output_line,  // Output line levels, fed back
    // Toward payload assembly
    output logic             o_meta_valid,   // Chunk values valid, one cycle
    output logic             o_append_active,// Metadata append mode
    output logic             o_ts_on,        // Time stamp chunk enabled
    output logic             o_cnt_on,       // Trigger count chunk enabled
    output logic             o_lines_on,     // Line snapshot chunk enabled
    output logic      [63:0] o_ts_chunk,     // Latched time stamp
    output logic      [31:0] o_cnt_chunk,    // Trigger count for the image
    output logic      [31:0] o_lines_chunk   // Line level snapshot
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                        wr_pend_ff, nxt_wr_pend;
    logic [7:0]                  wr_addr_ff, nxt_wr_addr;
    logic [31:0]                 hrdata_ff,  nxt_hrdata;
    logic [31:0]                 ts_hi_hold_ff, nxt_ts_hi_hold;
    logic                        append_ff,  nxt_append;
    imc_pkg::imc_kind_t          kind_sel_ff, nxt_kind_sel;
    logic [2:0]                  kind_on_ff, nxt_kind_on;
    logic                        pick_ff,    nxt_pick;
    logic [1:0]                  origin_ff,  nxt_origin;
    imc_pkg::imc_clear_t         clear_src_ff, nxt_clear_src;
    logic                        sw_clear;
    logic                        clear_req;
    logic [imc_pkg::PRE_W-1:0]   pre_ff,     nxt_pre;
    logic [imc_pkg::TS_W-1:0]    ts_ff,      nxt_ts;
    logic                        ts_tick;
    logic [imc_pkg::LINE_N-1:0]  line_lvl;
    logic [imc_pkg::LINE_N-1:0]  line_rise;
    logic [imc_pkg::CNT_W-1:0]   trig_cnt;
    logic [imc_pkg::SNAP_W-1:0]  snap_now;
    logic                        addr_phase;
    logic                        trig_d_ff,  nxt_trig_d;
    logic                        valid_ff,   nxt_valid;
    logic [63:0]                 ts_cap_ff,  nxt_ts_cap;
    logic [31:0]                 snap_cap_ff, nxt_snap_cap;
    logic [63:0]                 ts_out_ff,  nxt_ts_out;
    logic [31:0]                 cnt_out_ff, nxt_cnt_out;
    logic [31:0]                 snap_out_ff, nxt_snap_out;
    logic [2:0]                  on_sel;

    // ------------------------------------------------------------------
    // Line synchroniser and trigger counter
    // ------------------------------------------------------------------
    imc_line_sync u_line_sync (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_pin     ({i_output_line, i_input_line}),
        .o_level   (line_lvl),
        .o_rise    (line_rise)
    );

    // A trigger only counts outside free-run, where no external trigger exists
    imc_trig_counter u_trig_counter (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_count   (i_acq_trigger & ~i_free_run), // [R9]
        .i_clear   (clear_req),
        .o_count   (trig_cnt)
    );

    always_comb begin
        unique case (clear_src_ff)
            imc_pkg::IMC_CLR_LINE_ONE: clear_req = line_rise[0];          // [R11] [R20]
            imc_pkg::IMC_CLR_LINE_TWO: clear_req = line_rise[1];          // [R11] [R20]
            imc_pkg::IMC_CLR_SOFTWARE: clear_req = sw_clear;              // [R14]
            imc_pkg::IMC_CLR_OFF:      clear_req = 1'b0;                  // [R11]
        endcase
    end

    // Bit 0 line one, 1 line two, 2-3 output lines; the rest reads zero
    assign snap_now = {{(imc_pkg::SNAP_W - imc_pkg::LINE_N){1'b0}}, line_lvl}; // [R19] [R17]

    // ------------------------------------------------------------------
    // Time stamp counter
    // ------------------------------------------------------------------
    assign ts_tick = (pre_ff == imc_pkg::PRE_W'(imc_pkg::TS_TICK_CYC - 1));

    always_comb begin
        nxt_pre = ts_tick ? '0 : pre_ff + 8'h01;
        nxt_ts  = ts_tick ? ts_ff + 64'h0000_0000_0000_0001 : ts_ff; // [R1]
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pre_ff <= '0;
            ts_ff  <= imc_pkg::RST_TS; // [R2]
        end else begin
            pre_ff <= nxt_pre;
            ts_ff  <= nxt_ts;
        end
    end

    // ------------------------------------------------------------------
    // Trigger capture and chunk outputs
    // ------------------------------------------------------------------
    // Time stamp and lines are caught at the trigger edge; the count is
    // taken one cycle later so it already includes this trigger.
    always_comb begin
        nxt_trig_d   = i_acq_trigger;
        nxt_ts_cap   = i_acq_trigger ? ts_ff : ts_cap_ff;          // [R3]
        nxt_snap_cap = i_acq_trigger ? snap_now : snap_cap_ff;     // [R16]
        nxt_valid    = trig_d_ff;
        nxt_ts_out   = trig_d_ff ? ts_cap_ff : ts_out_ff;
        nxt_cnt_out  = trig_d_ff ? trig_cnt : cnt_out_ff;          // [R15]
        nxt_snap_out = trig_d_ff ? snap_cap_ff : snap_out_ff;      // [R18]
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            trig_d_ff   <= 1'b0;
            valid_ff    <= 1'b0;
            ts_cap_ff   <= '0;
            snap_cap_ff <= '0;
            ts_out_ff   <= '0;
            cnt_out_ff  <= '0;
            snap_out_ff <= '0;
        end else begin
            trig_d_ff   <= nxt_trig_d;
            valid_ff    <= nxt_valid;
            ts_cap_ff   <= nxt_ts_cap;
            snap_cap_ff <= nxt_snap_cap;
            ts_out_ff   <= nxt_ts_out;
            cnt_out_ff  <= nxt_cnt_out;
            snap_out_ff <= nxt_snap_out;
        end
    end

    assign o_meta_valid    = valid_ff;
    assign o_append_active = append_ff;
    assign o_ts_on         = kind_on_ff[imc_pkg::IMC_KIND_TS];        // [R3]
    assign o_cnt_on        = kind_on_ff[imc_pkg::IMC_KIND_CNT] & ~i_free_run; // [R9] [R15]
    assign o_lines_on      = kind_on_ff[imc_pkg::IMC_KIND_LINES];     // [R18]
    assign o_ts_chunk      = ts_out_ff;
    assign o_cnt_chunk     = cnt_out_ff;
    assign o_lines_chunk   = snap_out_ff;

    // ------------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------------
    // Read data is fetched at the address phase, so a read that follows a
    // write to the same register with no idle between sees the old value.
    assign addr_phase  = i_hsel & i_hready & i_htrans[1];
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = hrdata_ff;

    always_comb begin
        unique case (kind_sel_ff)
            imc_pkg::IMC_KIND_TS:    on_sel = 3'b001;
            imc_pkg::IMC_KIND_CNT:   on_sel = 3'b010;
            imc_pkg::IMC_KIND_LINES: on_sel = 3'b100;
            imc_pkg::IMC_KIND_RSVD:  on_sel = 3'b000;
        endcase
    end

    always_comb begin
        nxt_wr_pend    = addr_phase & i_hwrite;
        nxt_wr_addr    = addr_phase ? i_haddr[7:0] : wr_addr_ff;
        nxt_hrdata     = hrdata_ff;
        nxt_ts_hi_hold = ts_hi_hold_ff;
        if (addr_phase && !i_hwrite) begin
            nxt_hrdata = 32'h0000_0000;
            if (i_haddr[31:8] == 24'h00_0000) begin
                unique case (i_haddr[7:0])
                    imc_pkg::OFF_APPEND:   nxt_hrdata[imc_pkg::APPEND_BIT] = append_ff;
                    imc_pkg::OFF_KIND_SEL: nxt_hrdata[imc_pkg::KIND_SEL_LSB +: 2] = kind_sel_ff;
                    imc_pkg::OFF_KIND_ON:
                        nxt_hrdata[imc_pkg::KIND_ON_BIT] = |(kind_on_ff & on_sel);
                    imc_pkg::OFF_CNT_CFG: begin
                        nxt_hrdata[imc_pkg::PICK_BIT]            = pick_ff;
                        nxt_hrdata[imc_pkg::ORIGIN_LSB +: 2]     = origin_ff;
                        nxt_hrdata[imc_pkg::CLEAR_SRC_LSB +: 2]  = clear_src_ff;
                    end
                    imc_pkg::OFF_STATUS: begin
                        nxt_hrdata[imc_pkg::STAT_FREE_BIT]       = i_free_run;
                        nxt_hrdata[imc_pkg::STAT_ON_LSB +: 3]    = kind_on_ff;
                    end
                    // Low word read freezes the high word for a tear-free pair
                    imc_pkg::OFF_TS_LO: begin
                        nxt_hrdata     = ts_ff[31:0];
                        nxt_ts_hi_hold = ts_ff[63:32];
                    end
                    imc_pkg::OFF_TS_HI:    nxt_hrdata = ts_hi_hold_ff;
                    imc_pkg::OFF_TRIG_CNT: nxt_hrdata = i_free_run ? 32'h0000_0000 : trig_cnt;
                    imc_pkg::OFF_LINES:    nxt_hrdata = snap_cap_ff;
                    default:               nxt_hrdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_comb begin
        nxt_append    = append_ff;
        nxt_kind_sel  = kind_sel_ff;
        nxt_kind_on   = kind_on_ff;
        nxt_pick      = pick_ff;
        nxt_origin    = origin_ff;
        nxt_clear_src = clear_src_ff;
        sw_clear      = 1'b0;
        if (wr_pend_ff) begin
            unique case (wr_addr_ff)
                imc_pkg::OFF_APPEND: begin
                    nxt_append = i_hwdata[imc_pkg::APPEND_BIT];
                    if (!i_hwdata[imc_pkg::APPEND_BIT]) begin
                        nxt_kind_on = '0; // [R5]
                    end
                end
                imc_pkg::OFF_KIND_SEL:
                    nxt_kind_sel = imc_pkg::imc_kind_t'(i_hwdata[imc_pkg::KIND_SEL_LSB +: 2]);
                imc_pkg::OFF_KIND_ON: begin
                    // Enabling is ignored unless append mode is already on
                    if (append_ff) begin // [R4] [R6]
                        nxt_kind_on = i_hwdata[imc_pkg::KIND_ON_BIT] ?
                                      (kind_on_ff | on_sel) : (kind_on_ff & ~on_sel);
                    end
                end
                imc_pkg::OFF_CNT_CFG: begin
                    nxt_pick      = i_hwdata[imc_pkg::PICK_BIT];
                    nxt_origin    = i_hwdata[imc_pkg::ORIGIN_LSB +: 2];
                    nxt_clear_src =
                        imc_pkg::imc_clear_t'(i_hwdata[imc_pkg::CLEAR_SRC_LSB +: 2]); // [R11]
                end
                imc_pkg::OFF_CLEAR_CMD:
                    sw_clear = i_hwdata[imc_pkg::CMD_BIT] &
                               (clear_src_ff == imc_pkg::IMC_CLR_SOFTWARE); // [R14]
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_pend_ff    <= 1'b0;
            wr_addr_ff    <= 8'h00;
            hrdata_ff     <= 32'h0000_0000;
            ts_hi_hold_ff <= 32'h0000_0000;
            append_ff     <= imc_pkg::RST_APPEND;
            kind_sel_ff   <= imc_pkg::RST_KIND_SEL;
            kind_on_ff    <= imc_pkg::RST_KIND_ON;
            pick_ff       <= imc_pkg::RST_PICK;
            origin_ff     <= imc_pkg::RST_ORIGIN;
            clear_src_ff  <= imc_pkg::RST_CLEAR_SRC; // [R12]
        end else begin
            wr_pend_ff    <= nxt_wr_pend;
            wr_addr_ff    <= nxt_wr_addr;
            hrdata_ff     <= nxt_hrdata;
            ts_hi_hold_ff <= nxt_ts_hi_hold;
            append_ff     <= nxt_append;
            kind_sel_ff   <= nxt_kind_sel;
            kind_on_ff    <= nxt_kind_on;
            pick_ff       <= nxt_pick;
            origin_ff     <= nxt_origin;
            clear_src_ff  <= nxt_clear_src;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    ts_step_a: assert property (ts_tick |=> ts_ff == $past(ts_ff) + 64'h1) // [R1]
        else $error("time stamp did not advance on a tick");
    ts_latch_a: assert property (i_acq_trigger |-> ##2 o_ts_chunk == $past(ts_ff, 2)) // [R3]
        else $error("latched time stamp does not match trigger instant");
    kind_gate_a: assert property (!append_ff |-> kind_on_ff == 3'h0) // [R4]
        else $error("chunk enabled while append mode off");
    append_off_a: assert property (wr_pend_ff && wr_addr_ff == imc_pkg::OFF_APPEND
                                   && !i_hwdata[0] |=> kind_on_ff == 3'h0) // [R5]
        else $error("append mode off left a chunk enabled");
    free_run_a: assert property (i_free_run && !clear_req |=> $stable(trig_cnt)) // [R9]
        else $error("trigger count moved in free-run mode");
    line_clear_a: assert property (clear_src_ff == imc_pkg::IMC_CLR_LINE_ONE && line_rise[0]
                                   && !i_acq_trigger |=> trig_cnt == 32'h0) // [R20]
        else $error("line one edge did not clear the trigger count");
    cnt_chunk_a: assert property (i_acq_trigger && !i_free_run && !clear_req
                                  |-> ##2 o_cnt_chunk == $past(trig_cnt, 2) + 32'h1) // [R15]
        else $error("count chunk does not include its own trigger");
    snap_a: assert property (i_acq_trigger |-> ##2 o_lines_chunk == $past(snap_now, 2)) // [R16]
        else $error("line snapshot does not match trigger instant");

endmodule : imc_top

//--- test/imc_sink.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Payload assembly sink
// ---------------------------------------------------------------
module imc_sink (
    input  wire logic        i_clk_sys, // System clock
    input  wire logic        i_rstn,    // Async reset, active low
    input  wire logic        i_valid,   // Chunk values valid
    input  wire logic [31:0] i_cnt,     // Trigger count chunk
    input  wire logic [31:0] i_lines,   // Line snapshot chunk
    input  wire logic [63:0] i_ts,      // Time stamp chunk
    output logic      [31:0] o_cnt,     // Last count taken
    output logic      [31:0] o_lines,   // Last snapshot taken
    output logic      [63:0] o_ts,      // Last time stamp taken
    output logic      [7:0]  o_seen     // Images taken
);
    // Chunks are only trusted in the single cycle they are flagged valid
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_seen  <= 8'h00;
            o_cnt   <= 32'h0000_0000;
            o_lines <= 32'h0000_0000;
            o_ts    <= 64'h0000_0000_0000_0000;
        end else if (i_valid) begin
            o_seen  <= o_seen + 8'h01;
            o_cnt   <= i_cnt;
            o_lines <= i_lines;
            o_ts    <= i_ts;
        end
    end
endmodule : imc_sink

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0, rstn = 1'b0, trg = 1'b0, frun = 1'b0, hw = 1'b0;
    logic [1:0]  ht = 2'h0, inl = 2'h0, outl = 2'h0;
    logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, cc, lc, q, sc, sl;
    logic        hro, mv, aa, tson, cnton, lnon, hrs;
    logic [63:0] tc, st, t0;
    logic [7:0]  seen;
    logic [5:0]  rows [3] = '{6'h02, 6'h16, 6'h2e}; // Kind, expected enables
    int          bad_count = 0, n_checks = 0;
    imc_top i_imc_top (.i_clk_sys(clk), .i_rstn(rstn), .i_hsel(1'b1), .i_haddr(ha),
        .i_htrans(ht), .i_hwrite(hw), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hro),
        .o_hreadyout(hro), .o_hresp(hrs), .o_hrdata(hrd), .i_acq_trigger(trg),
        .i_free_run(frun), .i_input_line(inl), .i_output_line(outl), .o_meta_valid(mv),
        .o_append_active(aa), .o_ts_on(tson), .o_cnt_on(cnton), .o_lines_on(lnon),
        .o_ts_chunk(tc), .o_cnt_chunk(cc), .o_lines_chunk(lc));
    imc_sink i_imc_sink (.i_clk_sys(clk), .i_rstn(rstn), .i_valid(mv), .i_cnt(cc),
        .i_lines(lc), .i_ts(tc), .o_cnt(sc), .o_lines(sl), .o_ts(st), .o_seen(seen));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Trailing idle keeps a write and a following read apart
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        ht <= 2'h2;
        ha <= {24'h0, a};
        hw <= w;
        do @(posedge clk); while (hro !== 1'b1);
        ht <= 2'h0;
        hwd <= d;
        do @(posedge clk); while (hro !== 1'b1);
        q = hrd;
        @(posedge clk);
    endtask : bus
    task automatic trig();
        logic [7:0] k;
        k = seen;
        trg <= 1'b1;
        @(posedge clk);
        trg <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("images", k + 8'h01, seen);
        @(posedge clk);
    endtask : trig
    task automatic test_done();
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    initial forever #4 clk = ~clk;
    initial begin
        #20000;
        bad_count++;
        test_done();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        inl  <= 2'h1;
        outl <= 2'h2;
        @(posedge clk);
        bus(1'b0, 8'h0c, 32'h0); chk("clear_src", 32'h0, q);
        chk("hresp", 1'b0, hrs);
        bus(1'b1, 8'h08, 32'h1); bus(1'b0, 8'h14, 32'h0); chk("kind_off", 3'h0, q[3:1]);
        bus(1'b1, 8'h00, 32'h1);
        foreach (rows[i]) begin
            bus(1'b1, 8'h04, {30'h0, rows[i][5:4]});
            bus(1'b1, 8'h08, 32'h1);
            bus(1'b0, 8'h14, 32'h0); chk("enables", rows[i][3:0], {q[3:1], 1'b0});
        end
        chk("chunk_on", 4'hf, {aa, tson, cnton, lnon});
        trig(); t0 = st; chk("count", 32'h1, sc);
        chk("lines", 32'h9, sl);
        trig(); chk("ts_step", 64'h4, st - t0);
        chk("count", 32'h2, sc);
        bus(1'b0, 8'h24, 32'h0); chk("lines_reg", 32'h9, q);
        bus(1'b1, 8'h10, 32'h1); bus(1'b0, 8'h20, 32'h0); chk("clr_off", 32'h2, q);
        bus(1'b1, 8'h0c, 32'h300); bus(1'b1, 8'h10, 32'h1);
        bus(1'b0, 8'h20, 32'h0); chk("clr_sw", 32'h0, q);
        bus(1'b1, 8'h0c, 32'h100);
        inl <= 2'h0;
        repeat (4) @(posedge clk);
        trig(); chk("no_fall_clr", 32'h1, sc);
        inl <= 2'h1;
        repeat (4) @(posedge clk);
        trig(); chk("line_clr", 32'h1, sc);
        trig(); chk("one_clr", 32'h2, sc);
        frun <= 1'b1;
        trig(); bus(1'b0, 8'h20, 32'h0); chk("free_run", 32'h0, q);
        chk("free_cnt_on", 1'b0, cnton);
        bus(1'b0, 8'h14, 32'h0); chk("free_stat", 1'b1, q[0]);
        frun <= 1'b0;
        bus(1'b1, 8'h00, 32'h0); bus(1'b0, 8'h14, 32'h0); chk("all_off", 3'h0, q[3:1]);
        chk("append", 1'b0, aa);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'h20, 32'h0); chk("cnt_reset", 32'h0, q);
        bus(1'b0, 8'h18, 32'h0); chk("ts_restart", 1'b1, q < 32'h40);
        bus(1'b0, 8'h1c, 32'h0); chk("ts_hi", 32'h0, q);
        test_done();
    end
endmodule : tb_top
